// [hdl/aom_pkg.sv]
package aom_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned RES_W  = 24;

    // Register byte offsets
    localparam logic [7:0] REG_GAIN   = 8'h00;
    localparam logic [7:0] REG_SETUP  = 8'h04;
    localparam logic [7:0] REG_MODEL  = 8'h08;
    localparam logic [7:0] REG_HIRES  = 8'h0C;
    localparam logic [7:0] REG_FAST   = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    // Reset values
    localparam logic [7:0] GAIN_RST  = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [1:0] MODEL_RST = 2'h0;

    // Field positions
    localparam int unsigned GAIN_ENABLE_BIT = 7;
    localparam int unsigned SETUP_MODE_LSB  = 4;
    localparam int unsigned SETUP_TAP2_LSB  = 2;
    localparam int unsigned SETUP_TAP1_LSB  = 0;
    localparam int unsigned ST_HR_NEW       = 0;
    localparam int unsigned ST_FAST_NEW     = 1;
    localparam int unsigned ST_RUN          = 2;
    localparam int unsigned ST_PHASE        = 3;
    localparam int unsigned SAT_LSB         = 18;
    localparam int unsigned SAT_MSB         = 21;
    localparam int unsigned TRUNC_LSB       = 1;
    localparam int unsigned TRUNC_MSB       = 5;

    // Offset cycle modes
    localparam logic [1:0] MODE_SHORT  = 2'h0;
    localparam logic [1:0] MODE_CHOP   = 2'h1;
    localparam logic [1:0] MODE_RSVD   = 2'h2;
    localparam logic [1:0] MODE_DIRECT = 2'h3;

    // Resolution variants
    localparam logic [1:0] MODEL_5K  = 2'h0;
    localparam logic [1:0] MODEL_20K = 2'h1;
    localparam logic [1:0] MODEL_50K = 2'h2;

    // Saturation limits on the magnitude field
    localparam logic [3:0] SAT_LIMIT_WIDE = 4'hA;
    localparam logic [3:0] SAT_LIMIT_MID  = 4'h5;
    localparam logic [3:0] SAT_FILL       = 4'hF;

    // Filter lengths as log2 of taps, and result scaling
    localparam logic [3:0] LONG_LOG2_BASE  = 4'hB;
    localparam logic [3:0] SHORT_LOG2_BASE = 4'h5;
    localparam logic [4:0] LONG_SHIFT_BASE  = 5'h0A;
    localparam logic [4:0] SHORT_SHIFT_BASE = 5'h10;

endpackage

// [hdl/aom_comb.sv]
`timescale 1ns/100ps
// Boxcar integrator of the modulator bitstream over 2**log2n samples
module aom_comb (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                run,
    input  wire logic                bit_in,
    input  wire logic [3:0]          log2n,
    output logic                     done,
    output logic signed [15:0]       sum
);
    typedef struct packed {
        logic [13:0]        cnt;
        logic signed [15:0] acc;
    } aom_comb_st_t;

    aom_comb_st_t q;
    aom_comb_st_t d;
    logic [13:0]        last;
    logic signed [15:0] acc_next;

    // Count period end and accumulate +1 or -1 per sample
    always_comb begin
        d        = q;
        last     = (14'h0001 << log2n) - 14'h0001;
        acc_next = q.acc + (bit_in ? 16'sh0001 : -16'sh0001);
        if (!run) begin
            d.cnt = 14'h0000;
            d.acc = 16'sh0000;
        end else if (q.cnt == last) begin
            d.acc = 16'sh0000;
            d.cnt = 14'h0000;
        end else begin
            d.acc = acc_next;
            d.cnt = q.cnt + 14'h0001;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // End flagged in the cycle of the last sample, so chop flips on the boundary
    assign done = run && (q.cnt == last);
    assign sum  = acc_next;
endmodule

// [hdl/aom_buf2.sv]
`timescale 1ns/100ps
// Two-entry buffer; head entry drives the output directly
module aom_buf2 #(
    parameter int unsigned W = 24
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic         v_head;
        logic         v_tail;
    } aom_buf_st_t;

    aom_buf_st_t q;
    aom_buf_st_t d;

    // Pop shifts tail forward, push fills the first free slot
    always_comb begin
        d = q;
        if (q.v_head && out_ready) begin
            d.head   = q.tail;
            d.v_head = q.v_tail;
            d.v_tail = 1'b0;
        end
        if (in_valid && !q.v_tail) begin
            if (!d.v_head) begin
                d.head   = in_data;
                d.v_head = 1'b1;
            end else begin
                d.tail   = in_data;
                d.v_tail = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign in_ready  = !q.v_tail;
    assign out_valid = q.v_head;
    assign out_data  = q.head;
endmodule

// [hdl/aom_top.sv]
`timescale 1ns/100ps
// Functional notes
// - Mode 00 shorts the input; high-res result is the negated offset.
// - Mode 00 fast result also gives the negated offset for calibration.
// - Mode 11 high-res result is the conversion including offset.
// - Mode 11 fast result is the conversion including offset.
// - Mode 01 high-res result is the offset-free ideal conversion.
// - High-res updates once per long filter period; mode 01 half as often.
// - Mode 01 fast result is offset plus or minus signal by chop phase.
// - Fast result updates once per short filter period set by its tap field.
// - High-res result is a 24-bit two's-complement word.
// - Bit 23 of high-res result is the sign, 1 means negative.
// - Binary point sits between bits 21 and 20.
// - 5k and 50k variants saturate magnitude bits 21:18 above 1010 to 1111.
// - 20k variant saturates magnitude bits 21:18 above 0101 to 1111.
// - 5k variant forces high-res bits 5:1 to zero.
// - Enable bit 7 of gain register runs or stops the converter.
module aom_top
    import aom_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [aom_pkg::ADDR_W-1:0] paddr,
    input  wire logic [aom_pkg::DATA_W-1:0] pwdata,
    output logic [aom_pkg::DATA_W-1:0]      prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       mod_bit,
    output logic                            input_short,
    output logic                            chop_invert,
    output logic                            converter_run,
    output logic                            hr_valid,
    input  wire logic                       hr_ready,
    output logic [aom_pkg::RES_W-1:0]       hr_data,
    output logic [aom_pkg::RES_W-1:0]       fast_result
);
    import aom_pkg::*;

    typedef struct packed {
        logic [7:0]         gain;
        logic [7:0]         setup;
        logic [1:0]         model;
        logic [23:0]        hires;
        logic [23:0]        fast;
        logic signed [15:0] hold;
        logic               phase;
        logic               hr_new;
        logic               fast_new;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic               push;
        logic [23:0]        push_data;
        logic               short_o;
        logic               chop_o;
        logic               run_o;
    } aom_top_st_t;

    aom_top_st_t q;
    aom_top_st_t d;

    logic [1:0]         mode;
    logic [1:0]         tap1;
    logic [1:0]         tap2;
    logic               enable;
    logic               buf_ready;
    logic               long_done;
    logic               short_done;
    logic signed [15:0] long_sum;
    logic signed [15:0] short_sum;
    logic [3:0]         long_log2;
    logic [3:0]         short_log2;
    logic [23:0]        hr_next;
    logic               hr_update;
    logic               rd_hit;
    logic [31:0]        rd_word;
    logic               mapped;
    logic               acc_edge;

    // Sign-extend a count and scale it so 1.0 lands on bit 21
    function automatic logic [23:0] aom_scale(input logic signed [16:0] v,
                                              input logic [4:0] sh);
        logic signed [23:0] w;
        w = {{7{v[16]}}, v};
        return 24'(w <<< sh);
    endfunction

    // Apply per-variant saturation and truncation to a result word
    function automatic logic [23:0] aom_shape(input logic [23:0] v,
                                              input logic [1:0] model);
        logic [23:0] mag;
        logic [3:0]  lim;
        logic [23:0] r;
        mag = v[23] ? (24'h000000 - v) : v;
        lim = (model == MODEL_20K) ? SAT_LIMIT_MID : SAT_LIMIT_WIDE;
        if (mag[SAT_MSB:SAT_LSB] > lim) begin
            mag[SAT_MSB:SAT_LSB] = SAT_FILL;
        end
        r = v[23] ? (24'h000000 - mag) : mag;
        if (model == MODEL_5K) begin
            r[TRUNC_MSB:TRUNC_LSB] = 5'h00;
        end
        return r;
    endfunction

    // Field decode of the setup and gain registers
    assign mode       = q.setup[SETUP_MODE_LSB+1:SETUP_MODE_LSB];
    assign tap1       = q.setup[SETUP_TAP1_LSB+1:SETUP_TAP1_LSB];
    assign tap2       = q.setup[SETUP_TAP2_LSB+1:SETUP_TAP2_LSB];
    assign enable     = q.gain[GAIN_ENABLE_BIT];
    assign long_log2  = LONG_LOG2_BASE + {2'b00, tap1};
    assign short_log2 = SHORT_LOG2_BASE + {2'b00, tap2};

    // Long filter for the high-res result; stalls while the buffer is full
    aom_comb u_long (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce && buf_ready),
        .run    (enable),
        .bit_in (mod_bit),
        .log2n  (long_log2),
        .done   (long_done),
        .sum    (long_sum)
    );

    // Short filter for the fast result
    aom_comb u_short (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .run    (enable),
        .bit_in (mod_bit),
        .log2n  (short_log2),
        .done   (short_done),
        .sum    (short_sum)
    );

    // Result stream toward the receiver
    aom_buf2 #(
        .W (RES_W)
    ) u_buf (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (q.push),
        .in_ready  (buf_ready),
        .in_data   (q.push_data),
        .out_valid (hr_valid),
        .out_ready (hr_ready),
        .out_data  (hr_data)
    );

    // High-res result per mode at the end of each long period
    always_comb begin
        hr_next   = 24'h000000;
        hr_update = 1'b0;
        if (long_done && buf_ready) begin
            unique case (mode)
                MODE_SHORT: begin
                    hr_next   = aom_scale(-17'(long_sum), LONG_SHIFT_BASE - {3'b000, tap1});
                    hr_update = 1'b1;
                end
                MODE_CHOP: begin
                    // Half difference of two opposite-phase periods cancels the offset
                    hr_next   = aom_scale(17'(q.hold) - 17'(long_sum),
                                          LONG_SHIFT_BASE - 5'h01 - {3'b000, tap1});
                    hr_update = q.phase;
                end
                MODE_RSVD, MODE_DIRECT: begin
                    hr_next   = aom_scale(17'(long_sum), LONG_SHIFT_BASE - {3'b000, tap1});
                    hr_update = 1'b1;
                end
            endcase
        end
    end

    // Register read multiplexer
    always_comb begin
        mapped  = 1'b1;
        rd_word = 32'h00000000;
        unique case (paddr)
            REG_GAIN:   rd_word = {24'h000000, q.gain};
            REG_SETUP:  rd_word = {24'h000000, q.setup};
            REG_MODEL:  rd_word = {30'h00000000, q.model};
            REG_HIRES:  rd_word = {8'h00, q.hires};
            REG_FAST:   rd_word = {8'h00, q.fast};
            REG_STATUS: rd_word = {28'h0000000, q.phase, q.run_o, q.fast_new, q.hr_new};
            default:    mapped  = 1'b0;
        endcase
    end

    assign acc_edge = psel && penable && q.pready;
    assign rd_hit   = acc_edge && !pwrite;

    // Next state of registers, results and flags
    always_comb begin
        d         = q;
        d.push    = 1'b0;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;

        // Setup phase prepares a one-wait-free answer for the access phase
        if (psel && !penable && !q.pready) begin
            d.pready  = 1'b1;
            d.pslverr = !mapped;
            d.prdata  = rd_word;
        end

        // Writes take effect at the completing edge
        if (acc_edge && pwrite) begin
            unique case (paddr)
                REG_GAIN:  d.gain  = pwdata[7:0];
                REG_SETUP: d.setup = pwdata[7:0];
                REG_MODEL: d.model = pwdata[1:0];
                default:   d.gain  = q.gain;
            endcase
        end

        // Reading a result clears its new flag
        if (rd_hit && paddr == REG_HIRES) begin
            d.hr_new = 1'b0;
        end
        if (rd_hit && paddr == REG_FAST) begin
            d.fast_new = 1'b0;
        end

        // Chop phase alternates each long period in mode 01 only
        if (mode != MODE_CHOP || !enable) begin
            d.phase = 1'b0;
        end else if (long_done && buf_ready) begin
            d.phase = !q.phase;
            if (!q.phase) begin
                d.hold = long_sum;
            end
        end

        // New high-res word; a fresh result wins over a read clear
        if (hr_update) begin
            d.hires     = aom_shape(hr_next, q.model);
            d.push      = 1'b1;
            d.push_data = aom_shape(hr_next, q.model);
            d.hr_new    = 1'b1;
        end

        // Fast word; in mode 01 the raw sum already carries offset and chopped sign
        if (short_done) begin
            if (mode == MODE_SHORT) begin
                d.fast = aom_scale(-17'(short_sum), SHORT_SHIFT_BASE - {3'b000, tap2});
            end else begin
                d.fast = aom_scale(17'(short_sum), SHORT_SHIFT_BASE - {3'b000, tap2});
            end
            d.fast_new = 1'b1;
        end

        // Analog control outputs
        d.short_o = (mode == MODE_SHORT);
        d.chop_o  = d.phase;
        d.run_o   = d.gain[GAIN_ENABLE_BIT];
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q       <= '0;
            q.gain  <= GAIN_RST;
            q.setup <= SETUP_RST;
            q.model <= MODEL_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign input_short   = q.short_o;
    assign chop_invert   = q.chop_o;
    assign converter_run = q.run_o;
    assign fast_result   = q.fast;
endmodule

// [sim/aom_monitor.sv]
`timescale 1ns/100ps
module aom_monitor
    import aom_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       ce,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [aom_pkg::ADDR_W-1:0] paddr,
    input wire logic [aom_pkg::DATA_W-1:0] pwdata,
    input wire logic [aom_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       mod_bit,
    input wire logic                       input_short,
    input wire logic                       chop_invert,
    input wire logic                       converter_run,
    input wire logic                       hr_valid,
    input wire logic                       hr_ready,
    input wire logic [aom_pkg::RES_W-1:0]  hr_data,
    input wire logic [aom_pkg::RES_W-1:0]  fast_result
);
    typedef struct packed {
        logic [1:0] model;
        logic [1:0] mode;
    } aom_mon_t;
    aom_mon_t    mon_q;
    aom_mon_t    mon_d;
    logic        acc;
    logic [23:0] mag;
    // Shadow of model and mode fields, result magnitude
    always_comb begin
        acc = psel && penable && pready && pwrite;
        mon_d = mon_q;
        if (acc && paddr == REG_MODEL) mon_d.model = pwdata[1:0];
        if (acc && paddr == REG_SETUP) mon_d.mode = pwdata[SETUP_MODE_LSB +: 2];
        mag = hr_data[23] ? 24'h000000 - hr_data : hr_data;
    end
    // Shadow register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon_q <= '0;
        end else if (ce) begin
            mon_q <= mon_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_unmapped;
        psel && penable && pready && paddr > REG_STATUS |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_short;
        acc && paddr == REG_SETUP |-> ##2 input_short == (mon_q.mode == MODE_SHORT);
    endproperty
    a_short: assert property (p_short) else $error("input short wrong");
    property p_enable;
        acc && paddr == REG_GAIN |-> ##2 converter_run == $past(pwdata[GAIN_ENABLE_BIT], 2);
    endproperty
    a_enable: assert property (p_enable) else $error("run not from gain bit");
    property p_run_rise;
        $rose(hr_valid) |-> $past(converter_run, 4);
    endproperty
    a_run_rise: assert property (p_run_rise) else $error("word while stopped");
    property p_sign;
        hr_valid |-> hr_data[23] == hr_data[22];
    endproperty
    a_sign: assert property (p_sign) else $error("sign bits disagree");
    property p_sat;
        hr_valid |-> mag[21:18] == SAT_FILL
            || mag[21:18] <= (mon_q.model == MODEL_20K ? SAT_LIMIT_MID : SAT_LIMIT_WIDE);
    endproperty
    a_sat: assert property (p_sat) else $error("magnitude not saturated");
    property p_trunc;
        hr_valid && mon_q.model == MODEL_5K |-> hr_data[5:1] == 5'h00;
    endproperty
    a_trunc: assert property (p_trunc) else $error("low bits not cleared");
    property p_chop;
        $changed(chop_invert) |-> mon_q.mode == MODE_CHOP || $past(mon_q.mode, 2) == MODE_CHOP;
    endproperty
    a_chop: assert property (p_chop) else $error("chop moved outside chop mode");
endmodule

// [sim/aom_mod_model.sv]
`timescale 1ns/100ps
// Modulator: shorted input leaves a steady -1 offset stream,
// chopping swaps input polarity, a stopped modulator toggles
module aom_mod_model (
    input  wire logic clk,
    input  wire logic level,
    input  wire logic input_short,
    input  wire logic chop_invert,
    input  wire logic converter_run,
    output logic      mod_bit
);
    logic idle_q = 1'b0;
    // Idle pattern while stopped
    always @(posedge clk) idle_q <= ~idle_q;
    // Bit sampled by the filters
    assign mod_bit = !converter_run ? idle_q : input_short ? 1'b0 : level ^ chop_invert;
endmodule

// [sim/aom_top_bench.sv]
`timescale 1ns/100ps
module aom_top_bench;
    import aom_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, mod_bit, input_short, chop_invert, converter_run, hr_valid;
    logic        hr_ready = 1'b0;
    logic        level = 1'b0;
    logic [23:0] hr_data;
    logic [23:0] fast_result;
    int          n_fail = 0;
    int          compares = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    aom_top i_dut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mod_bit, .input_short, .chop_invert, .converter_run,
        .hr_valid, .hr_ready, .hr_data, .fast_result);
    aom_mod_model i_mod (.clk, .level, .input_short, .chop_invert, .converter_run, .mod_bit);
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wait_cy(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        chk("pready", 1, pready);
        if (pready !== 1'b1) close_out();
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic get_word(input logic [23:0] e, input int lo);
        int n;
        for (n = 0; hr_valid !== 1'b1 && n < 9000; n++) @(posedge clk);
        chk("word due", 1, hr_valid);
        if (hr_valid !== 1'b1) close_out();
        chk("hr data", {8'h00, e}, {8'h00, hr_data});
        chk("period", 1, n >= lo && n <= lo + 24);
        hr_ready <= 1'b1;
        @(posedge clk);
        hr_ready <= 1'b0;
    endtask
    // Stop, drain the buffer, set model, mode and input, restart
    task automatic arm(input logic [1:0] ml, input logic [1:0] md, input logic lv);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, REG_GAIN, 32'h0, rd, er);
        hr_ready <= 1'b1;
        wait_cy(4);
        hr_ready <= 1'b0;
        apb(1'b1, REG_MODEL, {30'h0, ml}, rd, er);
        apb(1'b1, REG_SETUP, {26'h0, md, 4'h0}, rd, er);
        level <= lv;
        apb(1'b1, REG_GAIN, 32'h0000_0080, rd, er);
    endtask
    task automatic t_regs();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, REG_SETUP, 32'h0, rd, er);
        chk("setup reset", {24'h0, SETUP_RST}, rd);
        chk("short at reset", 1, input_short);
        apb(1'b1, REG_GAIN, 32'h0000_007F, rd, er);
        apb(1'b0, REG_GAIN, 32'h0, rd, er);
        chk("gain rw", 32'h0000_007F, rd);
        chk("run off", 0, converter_run);
        apb(1'b1, REG_FAST, 32'hFFFF_FFFF, rd, er);
        chk("ro write err", 0, er);
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        $display("regs done");
    endtask
    task automatic t_table();
        logic [1:0]  ml [6] = '{MODEL_5K, MODEL_5K, MODEL_50K, MODEL_5K, MODEL_20K, MODEL_20K};
        logic [1:0]  md [6] = '{MODE_SHORT, MODE_DIRECT, MODE_RSVD, MODE_CHOP, MODE_DIRECT,
                                MODE_DIRECT};
        logic        lv [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [23:0] eh [6] = '{24'h200000, 24'hE00000, 24'hE00000, 24'h200000, 24'h3C0000,
                                24'hC40000};
        logic [23:0] ef [6] = '{24'h200000, 24'hE00000, 24'hE00000, 24'h000000, 24'h200000,
                                24'hE00000};
        logic [31:0] rd;
        logic        er;
        for (int i = 0; i < 6; i++) begin
            arm(ml[i], md[i], lv[i]);
            chk("input short", md[i] == MODE_SHORT, input_short);
            get_word(eh[i], md[i] == MODE_CHOP ? 4096 : 2048);
            if (md[i] != MODE_CHOP) chk("fast", {8'h00, ef[i]}, {8'h00, fast_result});
            apb(1'b0, REG_HIRES, 32'h0, rd, er);
            chk("hires reg", {8'h00, eh[i]}, rd);
        end
        $display("table done");
    endtask
    task automatic t_buffer();
        arm(MODEL_5K, MODE_DIRECT, 1'b1);
        wait_cy(4400);
        chk("buffer full", 1, hr_valid);
        chk("head word", 32'h0020_0000, {8'h00, hr_data});
        hr_ready <= 1'b1;
        wait_cy(2);
        chk("second word", 1, hr_valid);
        hr_ready <= 1'b0;
        wait_cy(1);
        chk("drained", 0, hr_valid);
        $display("buffer done");
    endtask
    task automatic t_disable();
        logic [31:0] rd;
        logic        er;
        arm(MODEL_5K, MODE_DIRECT, 1'b1);
        wait_cy(3);
        chk("run on", 1, converter_run);
        apb(1'b1, REG_GAIN, 32'h0, rd, er);
        wait_cy(2300);
        chk("run off", 0, converter_run);
        chk("no word", 0, hr_valid);
        $display("disable done");
    endtask
    // Main sequence
    initial begin
        wait_cy(3);
        rst <= 1'b0;
        wait_cy(1);
        t_regs();
        t_table();
        t_buffer();
        t_disable();
        close_out();
    end
endmodule
bind aom_top aom_monitor i_mon (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mod_bit, .input_short, .chop_invert, .converter_run,
    .hr_valid, .hr_ready, .hr_data, .fast_result);
